// ### include/dtc_pkg.sv
`default_nettype none
package dtc_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_TIMER_CONTROL     = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE_SELECT = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_LOW_BYTE   = 8'h8a;
  localparam logic [7:0] ADDR_TIMER1_LOW_BYTE   = 8'h8b;
  localparam logic [7:0] ADDR_TIMER0_HIGH_BYTE  = 8'h8c;
  localparam logic [7:0] ADDR_TIMER1_HIGH_BYTE  = 8'h8d;
  // Reset values
  localparam logic [7:0] RST_TIMER_CONTROL      = 8'h00;
  localparam logic [7:0] RST_TIMER_MODE_SELECT  = 8'h00;
  localparam logic [7:0] RST_COUNT              = 8'h00;
  // Control register fields
  localparam int OVF1_BIT = 7;
  localparam int RUN1_BIT = 6;
  localparam int OVF0_BIT = 5;
  localparam int RUN0_BIT = 4;
  // Mode register fields; timer 1 sits one nibble above timer 0
  localparam int GATE_BIT   = 3;
  localparam int SELECT_BIT = 2;
  localparam int MODE_HI    = 1;
  localparam int MODE_LO    = 0;
  localparam int TMR1_SHIFT = 4;
  // Modes
  localparam logic [1:0] MODE_PRESCALED = 2'h0;
  localparam logic [1:0] MODE_CASCADED  = 2'h1;
  localparam logic [1:0] MODE_RELOAD    = 2'h2;
  localparam logic [1:0] MODE_SPLIT     = 2'h3;
  // Machine cycle of 12 core clocks; state S(n)P(p) is phase 2(n-1)+p-1
  localparam logic [3:0] MC_LAST        = 4'hb;
  localparam logic [3:0] PH_INPUT_SAMPLE = 4'h9;
  localparam logic [3:0] PH_COUNT_UPDATE = 4'h4;
  localparam logic [4:0] PRESCALE_TOP   = 5'h1f;
endpackage : dtc_pkg
`default_nettype wire

// ### logic/dtc_timers.sv
// How it works
// R1 - Timer function adds one to the low byte every 12-clock machine cycle.
// R2 - Counter function samples count input once per cycle, counts high-then-low.
// R3 - The counted falling edge lands at the update state of next cycle.
// R4 - Edge recognition spans two machine cycles, so external rate is clock/24.
// R5 - The outside source holds each input level at least one machine cycle.
// R6 - Each timer has separately accessible high and low bytes, timer or counter.
// R7 - Mode register resets to zero; high nibble timer 1, low timer 0.
// R8 - Gate bit set: run only while gate pin high and run bit set.
// R9 - Select bit chooses count input when set, machine cycles when clear.
// R10 - Mode 00: high byte counts behind a 5-bit low-byte prescaler.
// R11 - Mode 01: high and low bytes form one 16-bit counter.
// R12 - Mode 10: low byte counts, reloaded from high byte on overflow.
// R13 - Mode 11 on timer 1 stops it, holding its value.
// R14 - Mode 11 on timer 0 splits it; high byte uses timer 1 controls.
// R15 - Control bits 6 and 4 are the run enables for timers 1 and 0.
// R16 - Control bits 7 and 5 are overflow flags, cleared on vectoring.
`default_nettype none
module dtc_timers
  import dtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       count_input_zero,
  input  wire logic       count_input_one,
  input  wire logic       gate_pin_zero,
  input  wire logic       gate_pin_one,
  input  wire logic       vector_ack_zero,
  input  wire logic       vector_ack_one,
  output logic            timer0_overflow_flag,
  output logic            timer1_overflow_flag
);
  import dtc_pkg::*;

  typedef struct packed {
    logic [3:0] phase;
    logic [7:0] mode_sel;
    logic [7:0] control;
    logic [7:0] lo0;
    logic [7:0] hi0;
    logic [7:0] lo1;
    logic [7:0] hi1;
    logic       samp0;
    logic       samp1;
    logic       pend0;
    logic       pend1;
    logic [7:0] rdata;
  } dtc_state_t;

  dtc_state_t st_q, st_d;

  ////////////////////////////////////////////////////////////////////////////
  // One count step: {overflow, high byte, low byte}
  function automatic logic [16:0] dtc_step(input logic [1:0] m,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (m)
      // R10 - prescaled high byte
      MODE_PRESCALED: begin
        if (lo[4:0] == PRESCALE_TOP) begin
          r = {hi == 8'hff, hi + 8'h01, lo[7:5], 5'h00};
        end else begin
          r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
        end
      end
      // R11 - 16-bit cascade
      MODE_CASCADED: r = {{hi, lo} == 16'hffff, {hi, lo} + 16'h0001};
      // R12 - reload from high byte
      MODE_RELOAD: begin
        if (lo == 8'hff) begin
          r = {1'b1, hi, hi};
        end else begin
          r = {1'b0, hi, lo + 8'h01};
        end
      end
      // Split: low byte only, 8-bit wrap
      MODE_SPLIT: r = {lo == 8'hff, hi, lo + 8'h01};
      default: r = {1'b0, hi, lo};
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Counting enables, evaluated once per machine cycle
  logic [1:0]  mode0, mode1;
  logic        upd, run0, run1, inc0, inc1, inc_hi0;
  logic [16:0] nx0, nx1;
  logic        set_ovf0, set_ovf1;

  always_comb begin
    mode0 = st_q.mode_sel[MODE_HI:MODE_LO];
    mode1 = st_q.mode_sel[TMR1_SHIFT+MODE_HI:TMR1_SHIFT+MODE_LO];
    upd   = st_q.phase == PH_COUNT_UPDATE;
    // R8 R15 - gate pin qualifies run bit
    run0 = st_q.control[RUN0_BIT] &&
           (!st_q.mode_sel[GATE_BIT] || gate_pin_zero);
    run1 = st_q.control[RUN1_BIT] &&
           (!st_q.mode_sel[TMR1_SHIFT+GATE_BIT] || gate_pin_one);
    // R9 R1 - event source: edge or every cycle
    inc0 = upd && run0 && (!st_q.mode_sel[SELECT_BIT] || st_q.pend0);
    // R13 - mode 11 freezes timer 1
    inc1 = upd && run1 && mode1 != MODE_SPLIT &&
           (!st_q.mode_sel[TMR1_SHIFT+SELECT_BIT] || st_q.pend1);
    // R14 - split high byte counts cycles on timer 1 run bit
    inc_hi0 = upd && mode0 == MODE_SPLIT && st_q.control[RUN1_BIT];
    nx0 = dtc_step(mode0, st_q.hi0, st_q.lo0);
    nx1 = dtc_step(mode1, st_q.hi1, st_q.lo1);
    set_ovf0 = inc0 && nx0[16];
    // R14 - in split mode timer 1 loses its flag to the high byte
    set_ovf1 = (inc_hi0 && st_q.hi0 == 8'hff) ||
               (inc1 && nx1[16] && mode0 != MODE_SPLIT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_d = st_q;
    // R1 - 12-clock machine cycle
    st_d.phase = (st_q.phase == MC_LAST) ? 4'h0 : st_q.phase + 4'h1;
    // R2 R4 - sample at input state, flag a high-to-low pair
    if (st_q.phase == PH_INPUT_SAMPLE) begin
      st_d.samp0 = count_input_zero;
      st_d.samp1 = count_input_one;
      st_d.pend0 = st_q.samp0 && !count_input_zero;
      st_d.pend1 = st_q.samp1 && !count_input_one;
    end
    // R3 - edge consumed at the update state of the next cycle
    if (upd) begin
      st_d.pend0 = 1'b0;
      st_d.pend1 = 1'b0;
    end
    if (inc0) begin
      st_d.lo0 = nx0[7:0];
      if (mode0 != MODE_SPLIT) st_d.hi0 = nx0[15:8];
    end
    if (inc_hi0) st_d.hi0 = st_q.hi0 + 8'h01;
    if (inc1) begin
      st_d.hi1 = nx1[15:8];
      st_d.lo1 = nx1[7:0];
    end
    // R16 - vectoring clears the flag
    if (vector_ack_zero) st_d.control[OVF0_BIT] = 1'b0;
    if (vector_ack_one)  st_d.control[OVF1_BIT] = 1'b0;
    // R6 R7 - byte writes win over counting
    if (sfr_wr) begin
      case (sfr_addr)
        ADDR_TIMER_CONTROL:     st_d.control  = sfr_wdata;
        ADDR_TIMER_MODE_SELECT: st_d.mode_sel = sfr_wdata;
        ADDR_TIMER0_LOW_BYTE:   st_d.lo0      = sfr_wdata;
        ADDR_TIMER1_LOW_BYTE:   st_d.lo1      = sfr_wdata;
        ADDR_TIMER0_HIGH_BYTE:  st_d.hi0      = sfr_wdata;
        ADDR_TIMER1_HIGH_BYTE:  st_d.hi1      = sfr_wdata;
        default: ;
      endcase
    end
    // R16 - an overflow beats any clear in the same cycle
    if (set_ovf0) st_d.control[OVF0_BIT] = 1'b1;
    if (set_ovf1) st_d.control[OVF1_BIT] = 1'b1;
    // Read data held until next read; unmapped reads return zero
    if (sfr_rd) begin
      case (sfr_addr)
        ADDR_TIMER_CONTROL:     st_d.rdata = st_q.control;
        ADDR_TIMER_MODE_SELECT: st_d.rdata = st_q.mode_sel;
        ADDR_TIMER0_LOW_BYTE:   st_d.rdata = st_q.lo0;
        ADDR_TIMER1_LOW_BYTE:   st_d.rdata = st_q.lo1;
        ADDR_TIMER0_HIGH_BYTE:  st_d.rdata = st_q.hi0;
        ADDR_TIMER1_HIGH_BYTE:  st_d.rdata = st_q.hi1;
        default:                st_d.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.mode_sel <= RST_TIMER_MODE_SELECT;
      st_q.control  <= RST_TIMER_CONTROL;
      st_q.lo0      <= RST_COUNT;
      st_q.hi0      <= RST_COUNT;
      st_q.lo1      <= RST_COUNT;
      st_q.hi1      <= RST_COUNT;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata            = st_q.rdata;
  assign timer0_overflow_flag = st_q.control[OVF0_BIT];
  assign timer1_overflow_flag = st_q.control[OVF1_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_PHASE_WRAP: assert property ( // R1
    st_q.phase == MC_LAST |=> st_q.phase == 4'h0 ##4 upd)
    else $error("machine cycle length wrong");
  AST_TIMER_TICK: assert property ( // R11
    upd && run0 && !st_q.mode_sel[SELECT_BIT] && mode0 == MODE_CASCADED
    && !sfr_wr |=> {st_q.hi0, st_q.lo0} ==
    $past({st_q.hi0, st_q.lo0}) + 16'h0001)
    else $error("timer 0 did not advance once");
  AST_SAMPLE_STATE: assert property ( // R2
    st_q.phase != PH_INPUT_SAMPLE |=> $stable(st_q.samp0))
    else $error("count input sampled off state");
  AST_FALL_SEEN: assert property ( // R4
    st_q.phase == PH_INPUT_SAMPLE && st_q.samp0 && !count_input_zero
    |=> st_q.pend0 [*7] ##1 !st_q.pend0)
    else $error("falling edge not held to update");
  AST_UPDATE_ONLY: assert property ( // R3
    !upd && !sfr_wr |=> $stable(st_q.lo0) && $stable(st_q.lo1))
    else $error("count moved outside update state");
  AST_GATED: assert property ( // R8
    st_q.mode_sel[GATE_BIT] && !gate_pin_zero && mode0 != MODE_SPLIT
    && !sfr_wr |=> $stable({st_q.hi0, st_q.lo0}))
    else $error("gated timer 0 counted");
  AST_RELOAD: assert property ( // R12
    inc0 && mode0 == MODE_RELOAD && st_q.lo0 == 8'hff && !sfr_wr
    |=> st_q.lo0 == $past(st_q.hi0) && timer0_overflow_flag)
    else $error("reload or flag missing");
  AST_T1_STOP: assert property ( // R13
    mode1 == MODE_SPLIT && !sfr_wr |=> $stable({st_q.hi1, st_q.lo1}))
    else $error("timer 1 moved in mode 11");
  AST_SPLIT_HIGH: assert property ( // R14
    upd && mode0 == MODE_SPLIT && st_q.control[RUN1_BIT] && !sfr_wr
    |=> st_q.hi0 == $past(st_q.hi0) + 8'h01)
    else $error("split high byte not counting");
  AST_SET_WINS: assert property ( // R16
    set_ovf0 |=> timer0_overflow_flag)
    else $error("overflow lost to clear");

  COV_EDGE_COUNT: cover property (inc0 && st_q.mode_sel[SELECT_BIT]);
  COV_PRESCALE_OVF: cover property (set_ovf0 && mode0 == MODE_PRESCALED);
  COV_SPLIT_OVF1: cover property (inc_hi0 && set_ovf1);
endmodule // dtc_timers
`default_nettype wire

// ### sim/dtc_pin_model.sv
`default_nettype none
module dtc_pin_model (
  input  wire logic clk,
  output var  logic count_input_zero,
  output var  logic count_input_one,
  output var  logic gate_pin_zero,
  output var  logic gate_pin_one
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pins idle high, as pulled up
  initial begin
    count_input_zero = 1'b1;
    count_input_one  = 1'b1;
    gate_pin_zero    = 1'b1;
    gate_pin_one     = 1'b1;
  end
  // hold each level
  // One machine cycle per level: fastest source that stays legal
  task automatic pulses(input logic t, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (12) @(negedge clk);
      count_input_zero = t;
      count_input_one  = !t;
      repeat (12) @(negedge clk);
      count_input_zero = 1'b1;
      count_input_one  = 1'b1;
    end
  endtask
  // Both gate pins move together
  task automatic gate(input logic v);
    gate_pin_zero = v;
    gate_pin_one  = v;
  endtask
endmodule // dtc_pin_model
`default_nettype wire

// ### sim/dtc_timers_tb.sv
`default_nettype none
module dtc_timers_tb
  import dtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, rst_n, sfr_wr, sfr_rd, ci0, ci1, gp0, gp1;
  logic       ack0, ack1, of0, of1;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  int         n_errors = 0;
  int         tests_run = 0;
  // 200 MHz core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  dtc_pin_model u_pins (.clk(clk), .count_input_zero(ci0),
    .count_input_one(ci1), .gate_pin_zero(gp0), .gate_pin_one(gp1));
  dtc_timers DUT (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_rdata(sfr_rdata), .count_input_zero(ci0),
    .count_input_one(ci1), .gate_pin_zero(gp0), .gate_pin_one(gp1),
    .vector_ack_zero(ack0), .vector_ack_one(ack1),
    .timer0_overflow_flag(of0), .timer1_overflow_flag(of1));
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobes stay high between back-to-back accesses
  task automatic wr(input logic [7:0] a, d);
    sfr_rd    = 1'b0;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(negedge clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, e);
    sfr_wr   = 1'b0;
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(negedge clk);
    chk(nm, e, sfr_rdata);
  endtask
  task automatic bytes(input logic t, input logic [7:0] lo, hi);
    rdc("low byte", ADDR_TIMER0_LOW_BYTE + 8'(t), lo);
    rdc("high byte", ADDR_TIMER0_HIGH_BYTE + 8'(t), hi);
  endtask
  task automatic flags(input logic e0, e1);
    chk("flag0", {7'h00, e0}, {7'h00, of0});
    chk("flag1", {7'h00, e1}, {7'h00, of1});
  endtask
  // Run enable stands for exactly n edges, so counts are exact
  task automatic run(input logic t, input logic [7:0] md, ct, lo, hi,
                     input int n);
    ack0 = 1'b1;
    ack1 = 1'b1;
    wr(ADDR_TIMER_CONTROL, 8'h00);
    ack0 = 1'b0;
    ack1 = 1'b0;
    wr(ADDR_TIMER0_LOW_BYTE + 8'(t), lo);
    wr(ADDR_TIMER0_HIGH_BYTE + 8'(t), hi);
    wr(ADDR_TIMER_MODE_SELECT, md);
    wr(ADDR_TIMER_CONTROL, ct);
    sfr_wr = 1'b0;
    repeat (n - 1) @(negedge clk);
    // Keep the flags, drop only run bits; next access lowers the strobe
    wr(ADDR_TIMER_CONTROL, {of1, 1'b0, of0, 5'h00});
  endtask
  ////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {rst_n, sfr_wr, sfr_rd, ack0, ack1} = 5'h00;
    sfr_addr  = 8'h00;
    sfr_wdata = 8'h00;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rdc("control", ADDR_TIMER_CONTROL, RST_TIMER_CONTROL);
    rdc("mode", ADDR_TIMER_MODE_SELECT, RST_TIMER_MODE_SELECT);
    rdc("unmapped", 8'h90, 8'h00);
    run(1'b0, 8'h01, 8'h10, 8'hfa, 8'hff, 120);
    bytes(1'b0, 8'h04, 8'h00);
    flags(1'b1, 1'b0);
    ack0 = 1'b1;
    @(negedge clk);
    ack0 = 1'b0;
    flags(1'b0, 1'b0);
    rdc("mode", ADDR_TIMER_MODE_SELECT, 8'h01);
    run(1'b0, 8'h00, 8'h10, 8'hfe, 8'h00, 36);
    bytes(1'b0, 8'he1, 8'h01);
    run(1'b0, 8'h02, 8'h10, 8'hfe, 8'hf0, 48);
    bytes(1'b0, 8'hf2, 8'hf0);
    flags(1'b1, 1'b0);
    u_pins.gate(1'b0);
    run(1'b0, 8'h09, 8'h10, 8'h00, 8'h00, 120);
    bytes(1'b0, 8'h00, 8'h00);
    u_pins.gate(1'b1);
    run(1'b0, 8'h09, 8'h10, 8'h00, 8'h00, 120);
    bytes(1'b0, 8'h0a, 8'h00);
    fork
      run(1'b1, 8'h50, 8'h40, 8'h00, 8'h00, 200);
      begin
        repeat (24) @(negedge clk);
        u_pins.pulses(1'b1, 5);
      end
    join
    bytes(1'b1, 8'h05, 8'h00);
    fork
      run(1'b0, 8'h05, 8'h10, 8'h00, 8'h00, 200);
      begin
        repeat (24) @(negedge clk);
        u_pins.pulses(1'b0, 5);
      end
    join
    bytes(1'b0, 8'h05, 8'h00);
    run(1'b1, 8'h30, 8'h40, 8'h0a, 8'h00, 120);
    bytes(1'b1, 8'h0a, 8'h00);
    run(1'b0, 8'h03, 8'h50, 8'h00, 8'hfc, 120);
    bytes(1'b0, 8'h0a, 8'h06);
    flags(1'b0, 1'b1);
    ack1 = 1'b1;
    @(negedge clk);
    ack1 = 1'b0;
    flags(1'b0, 1'b0);
    wrap_up();
  end
endmodule // dtc_timers_tb
`default_nettype wire
